// file: verilog/ucr_pkg.sv
// shared constants and types for the uart command and readout block
package ucr_pkg;
    localparam int REG_COUNT = 5;
    localparam int BAUD_WIDTH = 16;
    localparam logic [15:0] DEFAULT_BIT_PERIOD = 16'h00D0;
    localparam logic [7:0] SYNC_BYTE = 8'h55;
    localparam logic [3:0] CMD_RDATA_HI = 4'h1;
    localparam logic [3:0] CMD_REGISTER_READ_CMD_HI = 4'h2;
    localparam logic [3:0] CMD_REGISTER_WRITE_CMD_HI = 4'h4;
    localparam logic [2:0] REG_GAIN = 3'h0;
    localparam logic [2:0] REG_RATE = 3'h1;
    localparam logic [2:0] REG_READOUT = 3'h2;
    localparam logic [2:0] REG_ROUTING = 3'h3;
    localparam logic [2:0] REG_PIN = 3'h4;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int READY_BIT = 7;
    localparam int COUNT_EN_BIT = 6;
    localparam int INTEG_LSB = 4;
    localparam int TURBO_BIT = 4;
    localparam int AUTO_BIT = 0;
    localparam int PIN2_DIR_BIT = 6;
    localparam int PIN2_SEL_BIT = 3;
    localparam int PIN2_DAT_BIT = 2;
    localparam logic [7:0] READOUT_WMASK = 8'h7F;
    localparam logic [7:0] ROUTING_WMASK = 8'hFD;
    localparam logic [7:0] PIN_WMASK = 8'h7F;
    localparam logic [7:0] FULL_WMASK = 8'hFF;
    localparam logic [1:0] INTEG_NONE = 2'h0;
    localparam logic [1:0] INTEG_INVERT = 2'h1;
    localparam logic [1:0] INTEG_CRC = 2'h2;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam int CLK_PERIOD_NS = 40;
    localparam int STOP_TOL_NORMAL = 4;
    localparam int STOP_TOL_TURBO = 8;

    typedef enum {RX_IDLE, RX_MEAS, RX_START, RX_BITS, RX_STOP} ucr_rx_type;
    typedef enum {P_SYNC, P_CMD, P_WDATA} ucr_proto_type;

    typedef struct packed {
        logic [23:0] data;
        logic [7:0] count;
        logic [3:0] len;
        logic cnt_en;
        logic [1:0] integ;
    } ucr_frame_type;

    typedef struct packed {
        logic [7:0] pin;
        logic [7:0] routing;
        logic [7:0] readout;
        logic [7:0] rate;
        logic [7:0] gain;
    } ucr_config_type;

    function automatic logic [3:0] ucr_frame_len(logic cnt_en,
                                                 logic [1:0] integ);
        logic [3:0] n;
        n = 4'h3 + {3'h0, cnt_en};
        if (integ == INTEG_INVERT) begin
            n = n + 4'h3 + {3'h0, cnt_en};
        end else if (integ == INTEG_CRC) begin
            n = n + 4'h2;
        end
        return n;
    endfunction
endpackage

// file: verilog/ucr_tx_shifter.sv
// 8-n-1 byte transmitter at the measured bit period
`timescale 1ns/10ps
module ucr_tx_shifter import ucr_pkg::*; #(
    parameter int BAUD_W = BAUD_WIDTH
) (
    input wire logic i_clk, // system clock
    input wire logic i_reset_n, // async reset, active low
    input wire logic [BAUD_W-1:0] i_bit_per, // clocks per bit
    input wire logic i_valid, // byte offered
    input wire logic [7:0] i_byte, // byte to send
    output logic o_ready, // idle, byte taken on valid
    output logic o_tx // serial line, high at idle
);
    logic [9:0] sh;
    logic [3:0] bits;
    logic [BAUD_W-1:0] cnt;
    logic busy;
    logic [9:0] next_sh;
    logic [3:0] next_bits;
    logic [BAUD_W-1:0] next_cnt;
    logic next_busy;

    assign o_ready = !busy;
    assign o_tx = sh[0];

    always_comb begin
        next_sh = sh;
        next_bits = bits;
        next_cnt = cnt;
        next_busy = busy;
        if (!busy) begin
            if (i_valid) begin
                // start bit first, then data lsb first, then stop
                next_sh = {1'b1, i_byte, 1'b0};
                next_bits = 4'hA;
                next_cnt = '0;
                next_busy = 1'b1;
            end
        end else if (cnt == i_bit_per - 1'b1) begin
            next_cnt = '0;
            next_sh = {1'b1, sh[9:1]};
            next_bits = bits - 4'h1;
            if (bits == 4'h1) begin
                next_busy = 1'b0;
            end
        end else begin
            next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sh <= 10'h3FF;
            bits <= 4'h0;
            cnt <= '0;
            busy <= 1'b0;
        end else begin
            sh <= next_sh;
            bits <= next_bits;
            cnt <= next_cnt;
            busy <= next_busy;
        end
    end
endmodule // ucr_tx_shifter

// file: verilog/ucr_command_readout.sv
// uart command interpreter, configuration bank and result readout
//
// Function
// RULE1: write command stores its data byte into the addressed register.
// RULE2: write to a missing register address is discarded, nothing changes.
// RULE3: host sends 55h sync byte before every command.
// RULE4: accepted write pulses filter reset and conversion restart.
// RULE5: commands act only after their bytes are latched.
// RULE6: bytes latched at stop detection, half a bit into stop.
// RULE7: stop detection error at most 4 clocks normal, 8 turbo.
// RULE8: manual readout on read-result command; automatic sends each result.
// RULE9: ready on pin 2 only with direction output and ready select set.
// RULE10: ready status bit sets when a new result is available.
// RULE11: result arriving mid-transmission leaves sent bytes untouched.
// RULE12: optional counter byte follows result, advances per conversion.
// RULE13: polling host reads at least once per conversion period.
// RULE14: integrity field selects check bytes right after data bytes.
// RULE15: crc option appends exactly two check bytes.
// RULE16: inverted option appends three bytes, four with counter.
// RULE17: five 8-bit registers, read and write any time.
// RULE18: all registers reset to zero.
// RULE19: registers kept unchanged through power-down.
// RULE20: every byte is 8-n-1, start low, stop high.
// RULE21: words least significant byte first, bytes lsb first; the crc word is sent high byte first.
// RULE22: read-result command loads the most recent result.
// RULE23: register 3 bit 0 selects automatic readout.
// RULE24: ready bit in register 2 is read-only.
`timescale 1ns/10ps
module ucr_command_readout import ucr_pkg::*; #(
    parameter int BAUD_W = BAUD_WIDTH
) (
    input wire logic I_CLK, // 25 MHz system clock
    input wire logic I_RESET_N, // async reset, active low
    input wire logic I_RX, // uart receive pin
    input wire logic I_CONV_DONE, // conversion finished, one cycle
    input wire logic [23:0] I_CONV_DATA, // result valid with done
    output logic O_TX, // uart transmit pin
    output logic O_PIN2, // pin 2 output level
    output logic O_PIN2_OE, // pin 2 output enable
    output logic O_FILTER_RESTART, // filter reset and restart, one cycle
    output ucr_config_type O_CONFIG // configuration bank
);
    logic rx_s1, rx_s2, rx_prev;
    ucr_rx_type rx_state, next_rx_state;
    ucr_proto_type proto, next_proto;
    logic [BAUD_W-1:0] cnt, next_cnt, bit_per, next_bit_per;
    logic [2:0] bitn, next_bitn, cmd_addr, next_cmd_addr;
    logic [7:0] shreg, next_shreg;
    logic byte_done;
    logic wr_fire, next_wr_fire, rd_req, next_rd_req;
    logic register_read_cmd_req, next_register_read_cmd_req;
    logic [7:0] wr_data, next_wr_data;

    logic [7:0] cfg [REG_COUNT];
    logic [7:0] next_cfg [REG_COUNT];
    logic [23:0] res_data, next_res_data;
    logic [7:0] res_cnt, next_res_cnt;

    ucr_frame_type frame, next_frame;
    logic frame_active, next_frame_active;
    logic [3:0] idx, next_idx;
    logic [15:0] crc, next_crc;
    logic pend_rd, next_pend_rd, pend_register_read_cmd, next_pend_register_read_cmd;
    logic pend_auto, next_pend_auto;
    logic [2:0] register_read_cmd_addr, next_register_read_cmd_addr;
    logic load_res, tx_ready, tx_fire;
    logic [7:0] tx_byte;

    logic auto_mode, turbo;
    assign auto_mode = cfg[REG_ROUTING][AUTO_BIT]; // [RULE23]
    assign turbo = cfg[REG_RATE][TURBO_BIT];

    function automatic logic [7:0] wmask(logic [2:0] a);
        case (a)
            REG_READOUT: wmask = READOUT_WMASK;
            REG_ROUTING: wmask = ROUTING_WMASK;
            REG_PIN: wmask = PIN_WMASK;
            default: wmask = FULL_WMASK;
        endcase
    endfunction

    function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
        end
        return r;
    endfunction

    function automatic logic [7:0] data_byte(ucr_frame_type f,
                                             logic [3:0] j);
        case (j)
            4'h0: data_byte = f.data[7:0]; // [RULE21]
            4'h1: data_byte = f.data[15:8];
            4'h2: data_byte = f.data[23:16];
            default: data_byte = f.count;
        endcase
    endfunction

    // receiver and command decoder
    always_comb begin
        next_rx_state = rx_state;
        next_proto = proto;
        next_cnt = cnt + 1'b1;
        next_bit_per = bit_per;
        next_bitn = bitn;
        next_shreg = shreg;
        next_cmd_addr = cmd_addr;
        next_wr_data = wr_data;
        next_wr_fire = 1'b0;
        next_rd_req = 1'b0;
        next_register_read_cmd_req = 1'b0;
        byte_done = 1'b0;
        case (rx_state)
            RX_IDLE: begin
                next_cnt = '0;
                if (rx_prev && !rx_s2) begin
                    // sync start bit is exactly one host bit long
                    next_rx_state = (proto == P_SYNC) ? RX_MEAS : RX_START;
                end
            end
            RX_MEAS: begin
                if (rx_s2) begin
                    next_bit_per = cnt + 1'b1;
                    next_cnt = (cnt + 1'b1) >> 1;
                    next_bitn = '0;
                    next_rx_state = RX_BITS;
                end
            end
            RX_START: begin
                if (cnt == (bit_per >> 1) - 1'b1) begin
                    next_cnt = '0;
                    next_bitn = '0;
                    next_rx_state = rx_s2 ? RX_IDLE : RX_BITS;
                end
            end
            RX_BITS: begin
                if (cnt == bit_per - 1'b1) begin
                    next_cnt = '0;
                    next_shreg = {rx_s2, shreg[7:1]}; // [RULE21]
                    next_bitn = bitn + 3'h1;
                    if (bitn == 3'h7) begin
                        next_rx_state = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                // mid stop bit: one bit after the last data sample
                if (cnt == bit_per - 1'b1) begin // [RULE6] [RULE7]
                    next_rx_state = RX_IDLE;
                    byte_done = rx_s2; // [RULE20]
                    if (!rx_s2) begin
                        next_proto = P_SYNC;
                    end
                end
            end
            default: next_rx_state = RX_IDLE;
        endcase
        if (byte_done) begin // [RULE5]
            case (proto)
                P_SYNC: begin
                    if (shreg == SYNC_BYTE) begin // [RULE3]
                        next_proto = P_CMD;
                    end
                end
                P_CMD: begin
                    next_proto = P_SYNC;
                    next_cmd_addr = shreg[3:1];
                    if (shreg[7:4] == CMD_REGISTER_WRITE_CMD_HI) begin
                        next_proto = P_WDATA;
                    end else if (shreg[7:4] == CMD_REGISTER_READ_CMD_HI) begin
                        next_register_read_cmd_req = 1'b1;
                    end else if (shreg[7:4] == CMD_RDATA_HI) begin
                        next_rd_req = 1'b1;
                    end
                end
                P_WDATA: begin
                    next_proto = P_SYNC;
                    next_wr_data = shreg;
                    next_wr_fire = (cmd_addr < REG_COUNT); // [RULE1] [RULE2]
                end
                default: next_proto = P_SYNC;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_prev <= 1'b1;
            rx_state <= RX_IDLE;
            proto <= P_SYNC;
            cnt <= '0;
            bit_per <= DEFAULT_BIT_PERIOD[BAUD_W-1:0];
            bitn <= '0;
            shreg <= '0;
            cmd_addr <= '0;
            wr_data <= '0;
            wr_fire <= 1'b0;
            rd_req <= 1'b0;
            register_read_cmd_req <= 1'b0;
        end else begin
            rx_s1 <= I_RX;
            rx_s2 <= rx_s1;
            rx_prev <= rx_s2;
            rx_state <= next_rx_state;
            proto <= next_proto;
            cnt <= next_cnt;
            bit_per <= next_bit_per;
            bitn <= next_bitn;
            shreg <= next_shreg;
            cmd_addr <= next_cmd_addr;
            wr_data <= next_wr_data;
            wr_fire <= next_wr_fire;
            rd_req <= next_rd_req;
            register_read_cmd_req <= next_register_read_cmd_req;
        end
    end

    // configuration bank and latest result
    always_comb begin
        next_cfg = cfg;
        next_res_data = res_data;
        next_res_cnt = res_cnt;
        if (wr_fire) begin // [RULE1] [RULE17] [RULE24]
            next_cfg[cmd_addr] = (wr_data & wmask(cmd_addr))
                | (cfg[cmd_addr] & ~wmask(cmd_addr));
        end
        if (load_res) begin
            next_cfg[REG_READOUT][READY_BIT] = 1'b0;
        end
        if (I_CONV_DONE) begin // set wins over clear [RULE10]
            next_cfg[REG_READOUT][READY_BIT] = 1'b1;
            next_res_data = I_CONV_DATA;
            next_res_cnt = res_cnt + 8'h01; // [RULE12]
        end
    end

    // only reset clears the bank; power-down leaves it alone [RULE19]
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                cfg[i] <= REG_RESET; // [RULE18]
            end
            res_data <= '0;
            res_cnt <= '0;
        end else begin
            cfg <= next_cfg;
            res_data <= next_res_data;
            res_cnt <= next_res_cnt;
        end
    end

    // readout framing
    always_comb begin
        logic [3:0] n_data;
        logic [3:0] k;
        n_data = 4'h3 + {3'h0, frame.cnt_en};
        k = idx - n_data;
        next_frame = frame;
        next_frame_active = frame_active;
        next_idx = idx;
        next_crc = crc;
        next_pend_rd = pend_rd | rd_req;
        next_pend_register_read_cmd = pend_register_read_cmd | register_read_cmd_req;
        next_register_read_cmd_addr = register_read_cmd_req ? cmd_addr : register_read_cmd_addr;
        next_pend_auto = pend_auto | (I_CONV_DONE & auto_mode); // [RULE8]
        load_res = 1'b0;
        if (idx < n_data) begin
            tx_byte = data_byte(frame, idx); // [RULE14]
        end else if (frame.integ == INTEG_INVERT) begin
            tx_byte = ~data_byte(frame, k); // [RULE16]
        end else begin
            tx_byte = (k == 4'h0) ? crc[15:8] : crc[7:0]; // [RULE15]
        end
        if (tx_fire) begin
            if (idx < n_data) begin
                next_crc = crc_step(crc, tx_byte);
            end
            next_idx = idx + 4'h1;
            if (idx == frame.len - 4'h1) begin
                next_frame_active = 1'b0;
            end
        end
        // snapshot is fixed while it is sent [RULE11]
        if (!frame_active) begin
            next_idx = '0;
            next_crc = CRC_INIT;
            if (pend_register_read_cmd) begin
                next_pend_register_read_cmd = register_read_cmd_req;
                next_frame_active = 1'b1;
                next_frame = '0;
                next_frame.len = 4'h1;
                if (register_read_cmd_addr < REG_COUNT) begin
                    next_frame.data[7:0] = cfg[register_read_cmd_addr];
                end
            end else if (pend_rd || pend_auto) begin // [RULE22]
                // a request arriving in the load cycle stays pending
                next_pend_rd = rd_req;
                next_pend_auto = I_CONV_DONE & auto_mode; // [RULE8]
                load_res = 1'b1;
                next_frame_active = 1'b1;
                next_frame.data = res_data;
                next_frame.count = res_cnt;
                next_frame.cnt_en = cfg[REG_READOUT][COUNT_EN_BIT];
                next_frame.integ = cfg[REG_READOUT][INTEG_LSB +: 2];
                next_frame.len = ucr_frame_len(next_frame.cnt_en,
                                               next_frame.integ);
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            frame <= '0;
            frame_active <= 1'b0;
            idx <= '0;
            crc <= CRC_INIT;
            pend_rd <= 1'b0;
            pend_register_read_cmd <= 1'b0;
            pend_auto <= 1'b0;
            register_read_cmd_addr <= '0;
        end else begin
            frame <= next_frame;
            frame_active <= next_frame_active;
            idx <= next_idx;
            crc <= next_crc;
            pend_rd <= next_pend_rd;
            pend_register_read_cmd <= next_pend_register_read_cmd;
            pend_auto <= next_pend_auto;
            register_read_cmd_addr <= next_register_read_cmd_addr;
        end
    end

    assign tx_fire = frame_active & tx_ready;

    ucr_tx_shifter #(.BAUD_W(BAUD_W)) u_tx (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_bit_per(bit_per),
        .i_valid(frame_active),
        .i_byte(tx_byte),
        .o_ready(tx_ready),
        .o_tx(O_TX)
    );

    // pin 2 shows ready (active low) only when routed there [RULE9]
    always_comb begin
        O_PIN2_OE = cfg[REG_PIN][PIN2_DIR_BIT];
        O_PIN2 = cfg[REG_PIN][PIN2_SEL_BIT]
            ? !cfg[REG_READOUT][READY_BIT] : cfg[REG_PIN][PIN2_DAT_BIT];
    end

    assign O_FILTER_RESTART = wr_fire; // [RULE4]
    assign O_CONFIG = {cfg[REG_PIN], cfg[REG_ROUTING], cfg[REG_READOUT],
                       cfg[REG_RATE], cfg[REG_GAIN]};

    // cycles since the start edge, for the stop timing check
    logic [BAUD_W+3:0] since, stop_nom, stop_tol;
    // stop middle is nominally nine and a half bits after the start edge
    assign stop_nom = ({4'h0, bit_per} << 3) + {4'h0, bit_per}
        + {5'h0, bit_per[BAUD_W-1:1]};
    assign stop_tol = turbo ? (BAUD_W+4)'(STOP_TOL_TURBO)
        : (BAUD_W+4)'(STOP_TOL_NORMAL); // [RULE7]
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            since <= '0;
        end else if (rx_state == RX_IDLE && next_rx_state != RX_IDLE) begin
            since <= '0;
        end else begin
            since <= since + 1'b1;
        end
    end

    sequence s_wdata_latched;
        proto == P_WDATA && byte_done;
    endsequence

    a_register_write_cmd_store: assert property (@(posedge I_CLK) // [RULE1]
        disable iff (!I_RESET_N)
        s_wdata_latched ##1 wr_fire |=>
        ((cfg[cmd_addr] ^ wr_data) & wmask(cmd_addr)) == 8'h00)
        else $error("write did not store data");
    a_bad_addr_drop: assert property (@(posedge I_CLK) // [RULE2]
        disable iff (!I_RESET_N)
        (s_wdata_latched and (cmd_addr >= REG_COUNT)) |=> !wr_fire ##1
        !O_FILTER_RESTART)
        else $error("write to missing register acted");
    a_restart_pulse: assert property (@(posedge I_CLK) // [RULE4]
        disable iff (!I_RESET_N)
        (s_wdata_latched and (cmd_addr < REG_COUNT)) |=> O_FILTER_RESTART ##1
        !O_FILTER_RESTART)
        else $error("restart pulse missing after write");
    a_stop_timing: assert property (@(posedge I_CLK) // [RULE6] [RULE7]
        disable iff (!I_RESET_N)
        byte_done |-> since + stop_tol >= stop_nom
        && since <= stop_nom + stop_tol)
        else $error("byte latched off the stop bit middle");
    a_ready_sets: assert property (@(posedge I_CLK) // [RULE10]
        disable iff (!I_RESET_N)
        I_CONV_DONE |=> cfg[REG_READOUT][READY_BIT])
        else $error("ready bit not set after conversion");
    a_frame_frozen: assert property (@(posedge I_CLK) // [RULE11]
        disable iff (!I_RESET_N)
        frame_active && !tx_fire ##1 frame_active |-> $stable(frame))
        else $error("frame changed while sending");
    a_frame_length: assert property (@(posedge I_CLK) // [RULE15] [RULE16]
        disable iff (!I_RESET_N)
        load_res |=> frame.len == ucr_frame_len(frame.cnt_en, frame.integ)
        && frame.data == $past(res_data))
        else $error("result frame length or data wrong");
    a_auto_send: assert property (@(posedge I_CLK) // [RULE8]
        disable iff (!I_RESET_N)
        I_CONV_DONE && auto_mode && !frame_active && !pend_register_read_cmd
        |=> ##1 frame_active)
        else $error("automatic readout did not start");
    a_tx_idle_high: assert property (@(posedge I_CLK) // [RULE20]
        disable iff (!I_RESET_N)
        !frame_active && tx_ready |-> O_TX)
        else $error("tx not high at idle");
endmodule // ucr_command_readout

// file: dv/ucr_host_model.sv
// host uart model: commands on rx, collects bytes from tx
`timescale 1ns/10ps
module ucr_host_model import ucr_pkg::*; #(
    parameter int BIT = 16
) (
    input wire logic i_clk, // system clock
    input wire logic i_tx, // device transmit line
    output logic o_rx // device receive line, idle high
);
    logic [7:0] got[$];
    logic [7:0] sh;
    int bad_stop = 0;
    initial o_rx = 1'b1;
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0}; // start low, lsb first, stop high
        for (int i = 0; i < 10; i++) begin
            @(posedge i_clk);
            o_rx <= f[i];
            repeat (BIT - 1) @(posedge i_clk);
        end
    endtask
    task automatic command(input logic [7:0] c, input logic [7:0] d,
                           input bit two);
        send(SYNC_BYTE); // sync ahead of every command
        send(c);
        if (two) send(d);
    endtask
    always begin
        @(negedge i_tx);
        repeat (BIT / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge i_clk);
            sh[i] = i_tx;
        end
        repeat (BIT) @(posedge i_clk);
        if (i_tx !== 1'b1) bad_stop++;
        got.push_back(sh);
    end
endmodule // ucr_host_model

// file: dv/ucr_command_readout_test.sv
// self-checking bench for the uart command and readout block
`timescale 1ns/10ps
module ucr_command_readout_test import ucr_pkg::*;;
    localparam int BIT = 16;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic done = 1'b0;
    logic [23:0] data = 24'h00_0000;
    logic rx, tx, pin2, oe, rst_f;
    ucr_config_type cfg;
    int bad_count = 0;
    int tests_run = 0;
    int restarts = 0;
    logic [7:0] q[$];
    ucr_command_readout u_ucr_command_readout (.I_CLK(clk),
        .I_RESET_N(rst_n), .I_RX(rx), .I_CONV_DONE(done),
        .I_CONV_DATA(data), .O_TX(tx), .O_PIN2(pin2), .O_PIN2_OE(oe),
        .O_FILTER_RESTART(rst_f), .O_CONFIG(cfg));
    ucr_host_model #(.BIT(BIT)) u_ucr_host_model (.i_clk(clk),
        .i_tx(tx), .o_rx(rx));
    initial forever #20 clk = ~clk;
    always @(posedge clk) if (rst_f === 1'b1) restarts++;
    task automatic check(input logic [47:0] seen, input logic [47:0] want);
        tests_run++;
        if (seen !== want) begin
            bad_count++;
            $display("BAD %0t mismatch saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic conv(input logic [23:0] d);
        @(posedge clk);
        data <= d;
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic register_write_cmd(input logic [2:0] a, input logic [7:0] d);
        u_ucr_host_model.command({CMD_REGISTER_WRITE_CMD_HI, a, 1'b0}, d, 1'b1);
        repeat (4) @(posedge clk);
    endtask
    // optional command, optional conversion after first byte, count bytes
    task automatic frame(input logic [7:0] c, input int n, input bit mid,
                         input logic [23:0] d2);
        u_ucr_host_model.got.delete();
        if (c != 8'h00) u_ucr_host_model.command(c, 8'h00, 1'b0);
        for (int i = 0; i < 400 * BIT && u_ucr_host_model.got.size() < 1;
             i++) @(posedge clk);
        if (mid) conv(d2);
        for (int i = 0; i < 400 * BIT && u_ucr_host_model.got.size() < n;
             i++) @(posedge clk);
        repeat (30 * BIT) @(posedge clk);
        q = u_ucr_host_model.got;
        check(q.size(), n); // exact byte count
    endtask
    task automatic t_regs();
        logic [7:0] mask [5] = '{FULL_WMASK, FULL_WMASK, READOUT_WMASK,
                                 ROUTING_WMASK, PIN_WMASK};
        logic [39:0] exp = 40'h00_0000_0000;
        int r;
        check(cfg, exp);
        check({tx, oe}, 2'b10);
        for (int v = 0; v < 2; v++) begin
            for (int a = 0; a < 8; a++) begin
                r = restarts;
                register_write_cmd(a[2:0], v ? 8'h00 : 8'hFF);
                if (a < 5) exp[a*8 +: 8] = v ? 8'h00 : mask[a % 5];
                check(restarts - r, a < 5);
                check(cfg, exp);
                frame({CMD_REGISTER_READ_CMD_HI, a[2:0], 1'b0}, 1, 1'b0, 24'h00_0000);
                check(q[0], a < 5 ? exp[a*8 +: 8] : 8'h00);
            end
        end
    endtask
    task automatic t_ready();
        register_write_cmd(REG_PIN, 8'h48);
        check({oe, pin2}, 2'b11);
        conv(24'hA1_B2C3);
        check(cfg.readout[READY_BIT], 1'b1);
        check({oe, pin2}, 2'b10);
        frame(8'h10, 3, 1'b1, 24'h44_5566);
        check({q[2], q[1], q[0]}, 24'hA1_B2C3);
        frame(8'h10, 3, 1'b0, 24'h00_0000); // one poll per result
        check({q[2], q[1], q[0]}, 24'h44_5566);
        check(cfg.readout[READY_BIT], 1'b0);
        register_write_cmd(REG_PIN, 8'h40);
        check({oe, pin2}, 2'b10);
    endtask
    task automatic t_integrity();
        logic [7:0] modes [4] = '{8'h50, 8'h50, 8'h10, 8'h20};
        int lens [4] = '{8, 8, 6, 5};
        logic [7:0] cnt;
        for (int m = 0; m < 4; m++) begin
            register_write_cmd(REG_READOUT, modes[m]);
            conv(24'h12_3456);
            frame(8'h10, lens[m], 1'b0, 24'h00_0000);
            check({q[2], q[1], q[0]}, 24'h12_3456);
            for (int k = 0; k < lens[m] / 2 && modes[m][4]; k++)
                check(q[k + lens[m] / 2] ^ q[k], 8'hFF);
            if (m == 1) check(q[3], 8'(cnt + 8'h01));
            cnt = q[3];
        end
        register_write_cmd(REG_READOUT, 8'h00);
    endtask
    task automatic t_auto();
        register_write_cmd(REG_ROUTING, 8'h01);
        conv(24'h0A_0B0C);
        frame(8'h00, 6, 1'b1, 24'h0D_0E0F);
        check({q[5], q[4], q[3], q[2], q[1], q[0]},
              48'h0D0E_0F0A_0B0C);
        register_write_cmd(REG_ROUTING, 8'h00);
        conv(24'h00_0001);
        frame(8'h00, 0, 1'b0, 24'h00_0000); // manual sends nothing
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_regs();
        t_ready();
        t_integrity();
        t_auto();
        check(u_ucr_host_model.bad_stop, 0);
        conclude();
    end
    initial begin
        repeat (95000) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule // ucr_command_readout_test
